// [core/tzc_timer0_core.sv]
// timer zero counter with prescaler, reload, toggle, pwm and wishbone slave
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module tzc_timer0_core (
    input  wire logic        CLK_SYS_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        CPU_TICK_I,
    input  wire logic        OSC_TICK_I,
    input  wire logic        EVENT_PIN_I,
    input  wire logic        PIN_IRQ_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             PIN_IRQ_O,
    output logic             TOGGLE_OUT_O,
    output logic             TOGGLE_OE_O,
    output logic             PWM_OUT_O,
    output logic             WAKE_O,
    output logic             IRQ_O,
    output logic      [7:0]  COUNT_O
);
    import tzc_pkg::*;

    logic [7:0]       mode_r;
    logic [7:0]       flags_r;
    logic [7:0]       count_r;
    logic [7:0]       reload_buf_r;
    logic [7:0]       reload_r;
    logic [7:0]       presc_r;
    logic [2:0]       ev_sync_r;
    logic             toggle_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic lane0;
    assign lane0 = WB_SEL_I[0];
    assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && lane0;
    assign rd_en = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;

    function automatic logic hit(input logic [7:0] a);
        hit = wr_en && (WB_ADR_I == a);
    endfunction

    // combinational form of a counter write, for the checks below
    logic cnt_wr;
    assign cnt_wr = wr_en && (WB_ADR_I == ADDR_COUNT);

    // ------------------------------------------------------------
    // tick generation
    // ------------------------------------------------------------
    logic       ev_fall;
    logic       src_tick;
    logic [2:0] rate;
    logic [7:0] div_mask;
    logic       div_hit;
    logic       tick;
    assign rate    = mode_r[MODE_RATE_LO +: 3];
    // first sync stage only feeds the second
    assign ev_fall = ev_sync_r[2] && !ev_sync_r[1];
    // oscillator dividers are one step shorter than cpu ones
    assign src_tick = flags_r[FLAG_FAST] ? OSC_TICK_I : CPU_TICK_I;
    assign div_mask = (flags_r[FLAG_FAST] ? (CPU_DIV_BASE - 8'h01)
                                          : (CPU_DIV_BASE | (CPU_DIV_BASE - 8'h01))) >> rate;
    assign div_hit  = src_tick && ((presc_r & div_mask) == div_mask);
    // event mode ignores rate and fast flag
    assign tick = mode_r[MODE_CKS] ? ev_fall : div_hit;

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            ev_sync_r <= 3'h7;
        end else begin
            ev_sync_r <= {ev_sync_r[1:0], EVENT_PIN_I};
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            presc_r <= RST_BYTE;
        end else if (!mode_r[MODE_ENABLE]) begin
            presc_r <= RST_BYTE;
        end else if (src_tick) begin
            presc_r <= presc_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // boundary and overflow
    // ------------------------------------------------------------
    logic       pwm_on;
    logic [7:0] top;
    logic       ovf;
    logic       reload_on;
    assign pwm_on = mode_r[MODE_PWM];
    always_comb begin
        top = MAX_256;
        if (pwm_on) begin
            unique case ({mode_r[MODE_RELOAD], mode_r[MODE_TOGGLE]})
                2'b00: top = MAX_256;
                2'b01: top = MAX_64;
                2'b10: top = MAX_32;
                2'b11: top = MAX_16;
            endcase
        end
    end
    assign ovf       = mode_r[MODE_ENABLE] && tick && ((count_r & top) == top);
    assign reload_on = pwm_on || mode_r[MODE_RELOAD];

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            count_r <= RST_BYTE;
        end else if (hit(ADDR_COUNT)) begin
            count_r <= WB_DAT_I[7:0];
        end else if (ovf) begin
            count_r <= reload_on ? reload_buf_r : RST_BYTE;
        end else if (mode_r[MODE_ENABLE] && tick) begin
            count_r <= count_r + 8'h01;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            reload_buf_r <= RST_BYTE;
            reload_r     <= RST_BYTE;
        end else begin
            if (hit(ADDR_RELOAD)) begin
                reload_buf_r <= WB_DAT_I[7:0];
            end
            if (ovf) begin
                reload_r <= reload_buf_r;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs: toggle, pwm, wake, pin interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            toggle_r     <= 1'b0;
            TOGGLE_OUT_O <= 1'b0;
            TOGGLE_OE_O  <= 1'b1;
            PWM_OUT_O    <= 1'b0;
            WAKE_O       <= 1'b0;
            PIN_IRQ_O    <= 1'b0;
            COUNT_O      <= RST_BYTE;
        end else begin
            if (ovf) begin
                toggle_r <= !toggle_r;
            end
            // low enable means driven
            TOGGLE_OE_O  <= !(mode_r[MODE_TOGGLE] && !pwm_on);
            TOGGLE_OUT_O <= toggle_r;
            // simple duty: high once count reaches active reload value
            PWM_OUT_O    <= pwm_on && ((count_r & top) >= (reload_r & top)) &&
                            mode_r[MODE_ENABLE];
            WAKE_O       <= ovf && flags_r[FLAG_GREEN];
            PIN_IRQ_O    <= PIN_IRQ_I && !mode_r[MODE_CKS];
            COUNT_O      <= count_r;
        end
    end

    // ------------------------------------------------------------
    // registers and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            mode_r     <= RST_BYTE;
            flags_r    <= RST_BYTE;
            irq_mask_r <= '0;
        end else begin
            if (hit(ADDR_MODE)) begin
                mode_r <= WB_DAT_I[7:0];
            end
            if (hit(ADDR_CLOCK_FLAGS)) begin
                flags_r <= WB_DAT_I[7:0] & FLAGS_WMASK;
            end
            if (hit(ADDR_IRQ_MASK)) begin
                irq_mask_r <= WB_DAT_I[IRQ_W-1:0];
            end
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~(hit(ADDR_IRQ_STATUS) ? WB_DAT_I[IRQ_W-1:0] : '0))
                          | {ovf && flags_r[FLAG_GREEN], ovf};
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat_r & irq_mask_r);
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            WB_DAT_O <= '0;
            if (rd_en) begin
                unique case (WB_ADR_I)
                    ADDR_MODE:        WB_DAT_O <= {24'h0, mode_r};
                    ADDR_CLOCK_FLAGS: WB_DAT_O <= {24'h0, flags_r};
                    ADDR_COUNT:       WB_DAT_O <= {24'h0, count_r};
                    ADDR_IRQ_STATUS:  WB_DAT_O <= {30'h0, irq_stat_r};
                    ADDR_IRQ_MASK:    WB_DAT_O <= {30'h0, irq_mask_r};
                    default:          WB_DAT_O <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_count_inc;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (mode_r[MODE_ENABLE] && tick && !ovf && !cnt_wr) |=> (count_r == $past(count_r) + 8'h01);
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count did not step");

    property p_stop;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (!mode_r[MODE_ENABLE] && !cnt_wr) |=> $stable(count_r);
    endproperty
    a_stop: assert property (p_stop) else $error("count moved while disabled");

    property p_ovf_irq;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        ovf |=> irq_stat_r[IRQ_TIMEOUT];
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("time-out not flagged");

    property p_wrap;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ovf && !reload_on && !cnt_wr) |=> (count_r == RST_BYTE);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to zero");

    property p_reload;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ovf && reload_on && !cnt_wr) |=> (count_r == $past(reload_buf_r));
    endproperty
    a_reload: assert property (p_reload) else $error("reload not applied");

    property p_buf;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !ovf |=> $stable(reload_r);
    endproperty
    a_buf: assert property (p_buf) else $error("reload moved without overflow");

    property p_toggle;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        ovf |=> ##1 (TOGGLE_OUT_O != $past(TOGGLE_OUT_O));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_pin_irq;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        mode_r[MODE_CKS] |=> !PIN_IRQ_O;
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("pin irq in event mode");

    property p_wake;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (ovf && flags_r[FLAG_GREEN]) |=> WAKE_O;
    endproperty
    a_wake: assert property (p_wake) else $error("no green wake");

    property p_pwm16;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (pwm_on && mode_r[MODE_RELOAD] && mode_r[MODE_TOGGLE] && tick && mode_r[MODE_ENABLE]
         && count_r[3:0] == MAX_16[3:0]) |-> ovf;
    endproperty
    a_pwm16: assert property (p_pwm16) else $error("pwm 16 boundary missed");

    property p_event_hold;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (mode_r[MODE_CKS] && !ev_fall && !cnt_wr) |=> $stable(count_r);
    endproperty
    a_event_hold: assert property (p_event_hold) else $error("count moved without event");

    property p_presc_clear;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !mode_r[MODE_ENABLE] |=> (presc_r == RST_BYTE);
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept while disabled");

    property p_oe_pwm;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        pwm_on |=> TOGGLE_OE_O;
    endproperty
    a_oe_pwm: assert property (p_oe_pwm) else $error("toggle pin driven in pwm mode");

    property p_pwm_off;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !pwm_on |=> !PWM_OUT_O;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("pwm output without pwm mode");

    property p_no_wake;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        !flags_r[FLAG_GREEN] |=> !WAKE_O;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake without green enable");

    property p_irq_level;
        @(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        (|(irq_stat_r & irq_mask_r)) |=> IRQ_O;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("unmasked time-out not raised");
endmodule

// [dv/tzc_event_partner.sv]
// external event pin and pin interrupt source facing the timer
`timescale 1ns/1ps
module tzc_event_partner (
    input  wire logic clk_i,
    output logic      event_pin_o,
    output logic      pin_irq_o
);
    // pin has a pull-up, so it idles high between events
    // interrupt request held high so its suppression can be seen
    initial begin
        event_pin_o = 1'b1;
        pin_irq_o   = 1'b1;
    end
    // each level held four cycles so the three-flop synchroniser catches it
    task automatic fall();
        @(posedge clk_i);
        event_pin_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        event_pin_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// [dv/tzc_timer0_core_tb.sv]
// self-checking bench for the timer zero core
`timescale 1ns/1ps
module tzc_timer0_core_tb;
    import tzc_pkg::*;
    logic        clk, rst, cpu_t, osc_t, cyc, stb, we, ack, pin_irq_o, tog, tog_oe, pwm, wake, irq, ev_pin, pin_irq;
    logic [7:0]  adr, cnt_o, fl_r, md_r;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, rd;
    logic [7:0]  regs [5] = '{ADDR_CLOCK_FLAGS, ADDR_MODE, ADDR_COUNT, ADDR_RELOAD, 8'h10};
    int          n_mismatch, num_checks, seed, m_cnt, m_buf, m_st, m_msk, m_pre, m_tog, dv, n_wake, m_rel;

    tzc_timer0_core dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CPU_TICK_I(cpu_t), .OSC_TICK_I(osc_t),
        .EVENT_PIN_I(ev_pin), .PIN_IRQ_I(pin_irq), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .PIN_IRQ_O(pin_irq_o), .TOGGLE_OUT_O(tog), .TOGGLE_OE_O(tog_oe), .PWM_OUT_O(pwm),
        .WAKE_O(wake), .IRQ_O(irq), .COUNT_O(cnt_o));
    tzc_event_partner ev (.clk_i(clk), .event_pin_o(ev_pin), .pin_irq_o(pin_irq));
    // wake is a one-cycle pulse, so it is counted while it stands
    always @(posedge clk) begin
        if (wake === 1'b1) n_wake <= n_wake + 1;
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // bus, compare and verdict
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // holds the request until ack is sampled, no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) n_mismatch++;
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // one timer run: configure, feed ticks, compare with the model
    // ------------------------------------------------------------
    task automatic run(input logic [7:0] fl, input logic [7:0] md, input logic [7:0] c0, input logic [7:0] rl,
                       input int n);
        int top, div, w0, wk;
        logic pw, tg, ar;
        pw = md[MODE_PWM];
        tg = md[MODE_TOGGLE];
        ar = md[MODE_RELOAD];
        top = !pw ? 255 : ar ? (tg ? 15 : 31) : (tg ? 63 : 255);
        div = fl[FLAG_FAST] ? (128 >> md[6:4]) : (256 >> md[6:4]);
        // disable first so the prescaler starts from zero
        wb(1'b0 | 1'b1, ADDR_MODE, 32'h0);
        wb(1'b1, ADDR_CLOCK_FLAGS, {24'h0, fl});
        wb(1'b1, ADDR_COUNT, {24'h0, c0});
        wb(1'b1, ADDR_RELOAD, {24'h0, rl});
        wb(1'b1, ADDR_MODE, {24'h0, md});
        m_cnt = c0;
        m_buf = rl;
        m_pre = 0;
        m_tog = tog;
        w0 = n_wake;
        wk = 0;
        repeat (n) begin
            if (md[MODE_CKS]) begin
                ev.fall();
            end else begin
                @(posedge clk);
                osc_t <= fl[FLAG_FAST];
                cpu_t <= !fl[FLAG_FAST];
                @(posedge clk);
                osc_t <= 1'b0;
                cpu_t <= 1'b0;
            end
            if (md[MODE_ENABLE] && (md[MODE_CKS] || ++m_pre == div)) begin
                m_pre = 0;
                if ((m_cnt & top) == top) begin
                    m_cnt = (pw || ar) ? m_buf : 0;
                    m_st |= fl[FLAG_GREEN] ? 3 : 1;
                    m_tog ^= 1;
                    m_rel = m_buf;
                    if (fl[FLAG_GREEN]) wk++;
                end else begin
                    m_cnt++;
                end
            end
        end
        repeat (6) @(posedge clk);
        wb(1'b0, ADDR_COUNT, 32'h0);
        chk("count", m_cnt, rd);
        chk("count_out", m_cnt, {24'h0, cnt_o});
        wb(1'b0, ADDR_IRQ_STATUS, 32'h0);
        chk("status", m_st, rd);
        chk("irq", (m_st & m_msk) != 0, {31'h0, irq});
        chk("toggle_oe", !(tg && !pw), {31'h0, tog_oe});
        if (tg && !pw) chk("toggle", m_tog, {31'h0, tog});
        chk("pin_irq", !md[MODE_CKS], {31'h0, pin_irq_o});
        chk("wake", wk, n_wake - w0);
        chk("pwm", pw && md[MODE_ENABLE] && ((m_cnt & top) >= (m_rel & top)), {31'h0, pwm});
        wb(1'b1, ADDR_IRQ_STATUS, 32'h3);
        m_st = 0;
        repeat (3) @(posedge clk);
        chk("irq_clear", 0, {31'h0, irq});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        cpu_t = 1'b0;
        osc_t = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat_w = 32'h0;
        seed = 35220;
        n_mismatch = 0;
        num_checks = 0;
        m_st = 0;
        m_msk = 3;
        m_rel = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("oe_reset", 1, {31'h0, tog_oe});
        foreach (regs[i]) begin
            wb(1'b0, regs[i], 32'h0);
            chk("reset_read", 0, rd);
        end
        wb(1'b1, ADDR_CLOCK_FLAGS, 32'hff);
        wb(1'b0, ADDR_CLOCK_FLAGS, 32'h0);
        chk("flags", {24'h0, FLAGS_WMASK}, rd);
        wb(1'b1, 8'h10, 32'ha5);
        wb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 0, rd);
        wb(1'b1, ADDR_IRQ_MASK, 32'h3);
        run(8'h04, 8'hf4, 8'hfe, 8'h40, 3);
        run(8'h04, 8'hf2, 8'hff, 8'h00, 2);
        run(8'h06, 8'hf7, 8'h0e, 8'h05, 2);
        wb(1'b1, ADDR_IRQ_MASK, 32'h0);
        m_msk = 0;
        run(8'h04, 8'hf3, 8'h3f, 8'h07, 1);
        wb(1'b1, ADDR_IRQ_MASK, 32'h3);
        m_msk = 3;
        run(8'h04, 8'hf1, 8'hfe, 8'h10, 2);
        run(8'h04, 8'hf5, 8'h1e, 8'h02, 3);
        run(8'h04, 8'h74, 8'h20, 8'h00, 5);
        run(8'h00, 8'h8c, 8'hfd, 8'h30, 4);
        for (int i = 0; i < 4; i++) begin
            md_r = {1'b1, 3'($random(seed)), 4'h0};
            fl_r = i[0] ? 8'h04 : 8'h00;
            dv = i[0] ? (128 >> md_r[6:4]) : (256 >> md_r[6:4]);
            run(fl_r, md_r, 8'($random(seed)), 8'h00, dv * 2 + 1);
        end
        give_verdict();
    end
    // run needs a few thousand cycles; this bound only catches a hang
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule

// [pkg/tzc_pkg.sv]
// shared constants for the eight-bit timer/counter with pwm
package tzc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CLOCK_FLAGS = 8'hd8;
    localparam logic [7:0] ADDR_MODE        = 8'hda;
    localparam logic [7:0] ADDR_COUNT       = 8'hdb;
    localparam logic [7:0] ADDR_RELOAD      = 8'hcd;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'he0;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'he4;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_PWM      = 0;
    localparam int MODE_TOGGLE   = 1;
    localparam int MODE_RELOAD   = 2;
    localparam int MODE_CKS      = 3;
    localparam int MODE_RATE_LO  = 4;
    localparam int MODE_ENABLE   = 7;
    localparam int FLAG_GREEN    = 1;
    localparam int FLAG_FAST     = 2;
    localparam int FLAG_T1_FAST  = 3;
    localparam logic [7:0] FLAGS_WMASK = 8'h0e;
    // interrupt status bits
    localparam int IRQ_TIMEOUT   = 0;
    localparam int IRQ_WAKE      = 1;
    localparam int IRQ_W         = 2;
    // ------------------------------------------------------------
    // reset values and boundaries
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] MAX_256   = 8'hff;
    localparam logic [7:0] MAX_64    = 8'h3f;
    localparam logic [7:0] MAX_32    = 8'h1f;
    localparam logic [7:0] MAX_16    = 8'h0f;
    localparam logic [7:0] CPU_DIV_BASE = 8'h80;
endpackage
